/* common/tlb_fill_pkg.sv */
package tlb_fill_pkg;

	// ****************************************
	// Sizes and field layout
	// ****************************************
	localparam int ENTRIES = 64;
	localparam int PTR_W = 6;
	localparam int WORD_W = 64;
	localparam int VA_LO = 13;
	localparam int VA_HI = 42;
	localparam int TAG_W = 30;
	localparam int ASN_LO = 4;
	localparam int ASN_W = 7;
	localparam int MODE_LO = 3;
	localparam int MODE_W = 2;
	localparam int PTE_VALID_BIT = 0;
	localparam logic [63:0] PTE_KEEP_MASK = 64'hffff_ffff_0000_fffe;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [5:0] PTR_RESET = 6'h00;
	localparam logic [63:0] WORD_RESET = 64'h0;

	// ****************************************
	// Register selectors
	// ****************************************
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_SPACE,
		SEL_MODE,
		SEL_TAG,
		SEL_ENTRY,
		SEL_HOLD
	} reg_sel_e;

	typedef struct packed {
		logic wr;
		logic rd;
		reg_sel_e sel;
		logic [63:0] data;
	} reg_req_s;

	typedef struct packed {
		logic valid;
		logic [63:0] data;
	} reg_rsp_s;

endpackage

/* hw/tlb_victim_ptr.sv */
`timescale 1ns/1ps
module tlb_victim_ptr #(
	parameter int DEPTH = tlb_fill_pkg::ENTRIES
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic chip_reset_in,
	input wire logic step_in,
	input wire logic used_in,
	input wire logic [5:0] used_idx_in,
	output logic [5:0] ptr_out
);

	logic [5:0] ptr_q, ptr_d;
	logic [5:0] last_q, last_d;
	logic seen_q, seen_d;

	// ****************************************
	// Wrapping increment
	// ****************************************
	function automatic logic [5:0] bump(input logic [5:0] p);
		bump = (p == 6'(DEPTH - 1)) ? 6'h00 : p + 6'h01;
	endfunction

	always_comb begin
		ptr_d = ptr_q;
		seen_d = seen_q || used_in;
		last_d = used_in ? used_idx_in : last_q;
		if (chip_reset_in) begin
			ptr_d = tlb_fill_pkg::PTR_RESET;
			seen_d = 1'b0;
		end else if (step_in) begin
			ptr_d = bump(ptr_q);
			if (seen_d && bump(ptr_q) == last_d) begin
				ptr_d = bump(bump(ptr_q));
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ptr_q <= tlb_fill_pkg::PTR_RESET;
			last_q <= 6'h3f;
			seen_q <= 1'b0;
		end else begin
			ptr_q <= ptr_d;
			last_q <= last_d;
			seen_q <= seen_d;
		end
	end

	assign ptr_out = ptr_q;

	property p_wrap;
		@(posedge clock_in) disable iff (!rst_b_in)
		(step_in && !chip_reset_in && ptr_q == 6'(DEPTH - 1) && !(seen_d && last_d == 6'h00))
		|=> ptr_q == 6'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

	property p_chip_reset;
		@(posedge clock_in) disable iff (!rst_b_in)
		chip_reset_in |=> ptr_q == 6'h00;
	endproperty
	a_chip_reset: assert property (p_chip_reset) else $error("pointer not cleared");

endmodule

/* hw/tlb_entry_array.sv */
`timescale 1ns/1ps
module tlb_entry_array #(
	parameter int DEPTH = tlb_fill_pkg::ENTRIES
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic chip_reset_in,
	input wire logic wr_in,
	input wire logic [5:0] idx_in,
	input wire logic [29:0] tag_in,
	input wire logic [63:0] pte_in,
	output logic [63:0] pte_out,
	output logic [29:0] tag_out,
	output logic valid_out
);

	logic [63:0] pte_mem [DEPTH];
	logic [29:0] tag_mem [DEPTH];
	logic [DEPTH-1:0] valid_q, valid_d;

	// ****************************************
	// Valid bits
	// ****************************************
	always_comb begin
		valid_d = valid_q;
		if (chip_reset_in) begin
			valid_d = '0;
		end else if (wr_in) begin
			valid_d[idx_in] = 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			valid_q <= '0;
		end else begin
			valid_q <= valid_d;
		end
	end

	// ****************************************
	// Tag and entry storage
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (wr_in) begin
			tag_mem[idx_in] <= tag_in;
			pte_mem[idx_in] <= pte_in & tlb_fill_pkg::PTE_KEEP_MASK;
		end
	end

	assign pte_out = pte_mem[idx_in];
	assign tag_out = tag_mem[idx_in];
	assign valid_out = valid_q[idx_in];

	property p_fill_valid;
		@(posedge clock_in) disable iff (!rst_b_in)
		(wr_in && !chip_reset_in) |=> valid_q[$past(idx_in)];
	endproperty
	a_fill_valid: assert property (p_fill_valid) else $error("filled entry not valid");

	property p_clear;
		@(posedge clock_in) disable iff (!rst_b_in)
		chip_reset_in |=> valid_q == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("valid bits not cleared");

endmodule

/* hw/data_tlb_fill_and_readback.sv */
`timescale 1ns/1ps
// Contract
// - A tag write stores the tag and the staged entry into one buffer slot together.
// - The slot filled is the pointer value picked at the previous tag write or entry read by a not-last-used policy.
// - Every tag write advances the entry pointer.
// - Chip reset zeroes the pointer and valid bits; timeout reset leaves them alone.
// - The entry port fronts a 64-slot array using the memory layout with some fields dropped.
// - The entry valid bit is never stored in the array.
// - An entry write only loads the staging register until the next tag write.
// - Reading the entry port right after writing it does not return the written value.
// - An entry read copies the selected slot into the holding register and returns zero.
// - Every entry read advances the entry pointer.
// - The holding register is read-only and keeps the last entry read.
module data_tlb_fill_and_readback #(
	parameter int DEPTH = tlb_fill_pkg::ENTRIES
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic chip_reset_in,
	input wire logic timeout_reset_in,
	input wire tlb_fill_pkg::reg_req_s req_in,
	output tlb_fill_pkg::reg_rsp_s rsp_out,
	output logic [6:0] space_number_out,
	output logic [1:0] mode_out,
	output logic [5:0] entry_ptr_out,
	output logic [63:0] staged_out
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_q, rst_sync_q;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ****************************************
	// Decode
	// ****************************************
	logic tag_wr, entry_wr, entry_rd, hold_rd, space_wr, mode_wr;
	logic [5:0] ptr;
	logic [63:0] slot_pte;

	assign tag_wr = req_in.wr && req_in.sel == tlb_fill_pkg::SEL_TAG;
	assign entry_wr = req_in.wr && req_in.sel == tlb_fill_pkg::SEL_ENTRY;
	assign entry_rd = req_in.rd && req_in.sel == tlb_fill_pkg::SEL_ENTRY;
	assign hold_rd = req_in.rd && req_in.sel == tlb_fill_pkg::SEL_HOLD;
	assign space_wr = req_in.wr && req_in.sel == tlb_fill_pkg::SEL_SPACE;
	assign mode_wr = req_in.wr && req_in.sel == tlb_fill_pkg::SEL_MODE;

	// ****************************************
	// Pointer and array
	// ****************************************
	tlb_victim_ptr #(
		.DEPTH(DEPTH)
	) u_ptr (
		.clock_in(clock_in),
		.rst_b_in(rst_sync_q),
		.chip_reset_in(chip_reset_in),
		.step_in(tag_wr || entry_rd),
		.used_in(entry_rd),
		.used_idx_in(ptr),
		.ptr_out(ptr)
	);

	tlb_entry_array #(
		.DEPTH(DEPTH)
	) u_array (
		.clock_in(clock_in),
		.rst_b_in(rst_sync_q),
		.chip_reset_in(chip_reset_in),
		.wr_in(tag_wr),
		.idx_in(ptr),
		.tag_in(req_in.data[tlb_fill_pkg::VA_HI:tlb_fill_pkg::VA_LO]),
		.pte_in(staged_out),
		.pte_out(slot_pte),
		.tag_out(),
		.valid_out()
	);

	// ****************************************
	// Software-visible state
	// ****************************************
	logic [63:0] stage_q, stage_d;
	logic [63:0] hold_q, hold_d;
	logic [6:0] space_q, space_d;
	logic [1:0] mode_q, mode_d;
	tlb_fill_pkg::reg_rsp_s rsp_q, rsp_d;

	always_comb begin
		stage_d = stage_q;
		hold_d = hold_q;
		space_d = space_q;
		mode_d = mode_q;
		rsp_d.valid = req_in.rd;
		rsp_d.data = tlb_fill_pkg::WORD_RESET;
		if (entry_wr) begin
			stage_d = req_in.data;
		end
		if (space_wr) begin
			space_d = req_in.data[tlb_fill_pkg::ASN_LO +: tlb_fill_pkg::ASN_W];
		end
		if (mode_wr) begin
			mode_d = req_in.data[tlb_fill_pkg::MODE_LO +: tlb_fill_pkg::MODE_W];
		end
		if (entry_rd) begin
			hold_d = slot_pte;
			rsp_d.data = tlb_fill_pkg::WORD_RESET;
		end
		if (hold_rd) begin
			rsp_d.data = hold_q;
		end
	end

	always_ff @(posedge clock_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			stage_q <= tlb_fill_pkg::WORD_RESET;
			hold_q <= tlb_fill_pkg::WORD_RESET;
			space_q <= 7'h00;
			mode_q <= 2'h0;
			rsp_q <= '0;
		end else begin
			stage_q <= stage_d;
			hold_q <= hold_d;
			space_q <= space_d;
			mode_q <= mode_d;
			rsp_q <= rsp_d;
		end
	end

	assign rsp_out = rsp_q;
	assign space_number_out = space_q;
	assign mode_out = mode_q;
	assign entry_ptr_out = ptr;
	assign staged_out = stage_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_entry_rd_zero;
		@(posedge clock_in) disable iff (!rst_sync_q)
		entry_rd |=> rsp_out.valid && rsp_out.data == 64'h0;
	endproperty
	a_entry_rd_zero: assert property (p_entry_rd_zero) else $error("entry read not zero");

	property p_no_echo;
		@(posedge clock_in) disable iff (!rst_sync_q)
		entry_wr ##1 entry_rd |=> rsp_out.data == 64'h0;
	endproperty
	a_no_echo: assert property (p_no_echo) else $error("written entry echoed");

	property p_stage_only;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(entry_wr && !tag_wr) |=> staged_out == $past(req_in.data);
	endproperty
	a_stage_only: assert property (p_stage_only) else $error("staging not loaded");

	property p_hold_keep;
		@(posedge clock_in) disable iff (!rst_sync_q)
		!entry_rd |=> hold_q == $past(hold_q);
	endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("holding changed");

	property p_hold_return;
		@(posedge clock_in) disable iff (!rst_sync_q)
		hold_rd |=> rsp_out.data == $past(hold_q);
	endproperty
	a_hold_return: assert property (p_hold_return) else $error("holding not returned");

	property p_tag_step;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(tag_wr && !chip_reset_in) |=> ptr != $past(ptr);
	endproperty
	a_tag_step: assert property (p_tag_step) else $error("pointer did not step");

	property p_read_step;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(entry_rd && !chip_reset_in) |=> ptr != $past(ptr);
	endproperty
	a_read_step: assert property (p_read_step) else $error("pointer did not step");

	property p_timeout_keep;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(timeout_reset_in && !chip_reset_in && !tag_wr && !entry_rd) |=> ptr == $past(ptr);
	endproperty
	a_timeout_keep: assert property (p_timeout_keep) else $error("timeout moved pointer");

	property p_mode_copy;
		@(posedge clock_in) disable iff (!rst_sync_q)
		mode_wr |=> mode_out == $past(req_in.data[4:3]);
	endproperty
	a_mode_copy: assert property (p_mode_copy) else $error("mode not loaded");

	property p_space_copy;
		@(posedge clock_in) disable iff (!rst_sync_q)
		space_wr |=> space_number_out == $past(req_in.data[10:4]);
	endproperty
	a_space_copy: assert property (p_space_copy) else $error("space number not loaded");

	property p_space_keep;
		@(posedge clock_in) disable iff (!rst_sync_q)
		!space_wr |=> $stable(space_number_out);
	endproperty
	a_space_keep: assert property (p_space_keep) else $error("space number changed");

	property p_mode_keep;
		@(posedge clock_in) disable iff (!rst_sync_q)
		!mode_wr |=> $stable(mode_out);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode changed");

	property p_stage_keep;
		@(posedge clock_in) disable iff (!rst_sync_q)
		!entry_wr |=> $stable(staged_out);
	endproperty
	a_stage_keep: assert property (p_stage_keep) else $error("staging changed");

	property p_rsp_valid;
		@(posedge clock_in) disable iff (!rst_sync_q)
		req_in.rd |=> rsp_out.valid;
	endproperty
	a_rsp_valid: assert property (p_rsp_valid) else $error("read not answered");

	property p_rsp_idle;
		@(posedge clock_in) disable iff (!rst_sync_q)
		!req_in.rd |=> !rsp_out.valid && rsp_out.data == 64'h0;
	endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("answer without read");

	property p_refused_zero;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(req_in.rd && !hold_rd) |=> rsp_out.data == 64'h0;
	endproperty
	a_refused_zero: assert property (p_refused_zero) else $error("read data not zero");

	property p_hold_load;
		@(posedge clock_in) disable iff (!rst_sync_q)
		entry_rd |=> hold_q == $past(slot_pte);
	endproperty
	a_hold_load: assert property (p_hold_load) else $error("holding not loaded");

	property p_hold_mask;
		@(posedge clock_in) disable iff (!rst_sync_q)
		entry_rd |=> (hold_q & ~tlb_fill_pkg::PTE_KEEP_MASK) == 64'h0;
	endproperty
	a_hold_mask: assert property (p_hold_mask) else $error("dropped field read back");

	property p_hold_wr_ignored;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(req_in.wr && req_in.sel == tlb_fill_pkg::SEL_HOLD) |=> $stable(hold_q);
	endproperty
	a_hold_wr_ignored: assert property (p_hold_wr_ignored) else $error("holding written");

	property p_hold_rd_valid;
		@(posedge clock_in) disable iff (!rst_sync_q)
		hold_rd |=> rsp_out.valid;
	endproperty
	a_hold_rd_valid: assert property (p_hold_rd_valid) else $error("holding read lost");

	property p_entry_wr_ptr;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(entry_wr && !chip_reset_in) |=> $stable(ptr);
	endproperty
	a_entry_wr_ptr: assert property (p_entry_wr_ptr) else $error("entry write moved pointer");

	property p_idle_ptr;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(!tag_wr && !entry_rd && !chip_reset_in) |=> $stable(ptr);
	endproperty
	a_idle_ptr: assert property (p_idle_ptr) else $error("pointer moved while idle");

	property p_step_size;
		@(posedge clock_in) disable iff (!rst_sync_q)
		((tag_wr || entry_rd) && !chip_reset_in) |=> 6'(ptr - $past(ptr)) inside {6'h01, 6'h02};
	endproperty
	a_step_size: assert property (p_step_size) else $error("pointer step out of range");

	// ****************************************
	// Committed slot checks
	// ****************************************
	property p_commit_pte;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(tag_wr && !chip_reset_in) |=>
			u_array.pte_mem[$past(ptr)] == ($past(staged_out) & tlb_fill_pkg::PTE_KEEP_MASK);
	endproperty
	a_commit_pte: assert property (p_commit_pte) else $error("staged entry not committed");

	property p_commit_tag;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(tag_wr && !chip_reset_in) |=>
			u_array.tag_mem[$past(ptr)] == $past(req_in.data[42:13]);
	endproperty
	a_commit_tag: assert property (p_commit_tag) else $error("tag not committed");

	property p_commit_no_valid;
		@(posedge clock_in) disable iff (!rst_sync_q)
		(tag_wr && !chip_reset_in) |=> !u_array.pte_mem[$past(ptr)][tlb_fill_pkg::PTE_VALID_BIT];
	endproperty
	a_commit_no_valid: assert property (p_commit_no_valid) else $error("valid bit stored");

endmodule

/* tb/test_data_tlb_fill_and_readback.sv */
`timescale 1ns/1ps
module test_data_tlb_fill_and_readback;
	typedef struct packed {
		tlb_fill_pkg::reg_sel_e sel;
		logic wr;
		logic [63:0] data;
		logic [63:0] exp_rsp;
		logic [6:0] exp_space;
		logic [1:0] exp_mode;
	} row_s;
	logic clock_in;
	logic rst_b_in;
	logic chip_reset_in;
	logic timeout_reset_in;
	tlb_fill_pkg::reg_req_s req_in;
	tlb_fill_pkg::reg_rsp_s rsp_out;
	logic [6:0] space_number_out;
	logic [1:0] mode_out;
	logic [5:0] entry_ptr_out;
	logic [63:0] staged_out;
	tlb_fill_pkg::reg_rsp_s got;
	row_s rows [6];
	int n_mismatch;
	int checks_done;
	int cycles;

	data_tlb_fill_and_readback u_dut (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.chip_reset_in(chip_reset_in),
		.timeout_reset_in(timeout_reset_in),
		.req_in(req_in),
		.rsp_out(rsp_out),
		.space_number_out(space_number_out),
		.mode_out(mode_out),
		.entry_ptr_out(entry_ptr_out),
		.staged_out(staged_out)
	);

	// ****************************************
	// Clock and hang guard
	// ****************************************
	initial begin
		clock_in = 1'b0;
		forever begin
			#10 clock_in = ~clock_in;
		end
	end

	initial begin
		cycles = 0;
		forever begin
			@(posedge clock_in);
			cycles++;
			if (cycles >= 5000) begin
				n_mismatch++;
				$display("BAD %0t run took too long", $time);
				test_done();
			end
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [63:0] fill(input int i);
		return {32'(i) * 32'h0101_0101 ^ 32'hc3c3_0000, 16'h5a5a, 16'(i) * 16'h0203 | 16'h0001};
	endfunction

	task automatic chk(input logic [63:0] got_v, input logic [63:0] exp_v, input string what);
		checks_done++;
		if (got_v !== exp_v) begin
			n_mismatch++;
			$display("BAD %0t %s got %h want %h", $time, what, got_v, exp_v);
		end
	endtask

	task automatic acc(input tlb_fill_pkg::reg_sel_e sel, input logic wr, input logic [63:0] data);
		@(negedge clock_in);
		req_in = '{wr: wr, rd: !wr, sel: sel, data: data};
		@(negedge clock_in);
		req_in = '0;
		got = rsp_out;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_b_in = 1'b0;
		chip_reset_in = 1'b0;
		timeout_reset_in = 1'b0;
		req_in = '0;
		n_mismatch = 0;
		checks_done = 0;
		rows[0] = '{tlb_fill_pkg::SEL_SPACE, 1'b1, 64'h7f0, 64'h0, 7'h7f, 2'h0};
		rows[1] = '{tlb_fill_pkg::SEL_MODE, 1'b1, 64'h18, 64'h0, 7'h7f, 2'h3};
		rows[2] = '{tlb_fill_pkg::SEL_SPACE, 1'b0, 64'h0, 64'h0, 7'h7f, 2'h3};
		rows[3] = '{tlb_fill_pkg::SEL_MODE, 1'b0, 64'h0, 64'h0, 7'h7f, 2'h3};
		rows[4] = '{tlb_fill_pkg::SEL_TAG, 1'b0, 64'h0, 64'h0, 7'h7f, 2'h3};
		rows[5] = '{tlb_fill_pkg::SEL_SPACE, 1'b1, 64'hffff_ffff_ffff_f81f, 64'h0, 7'h01, 2'h3};
		repeat (8) @(negedge clock_in);
		rst_b_in = 1'b1;
		repeat (3) @(negedge clock_in);
		chk(64'(entry_ptr_out), 64'h0, "pointer after reset");
		for (int r = 0; r < 6; r++) begin
			acc(rows[r].sel, rows[r].wr, rows[r].data);
			chk(64'(space_number_out), 64'(rows[r].exp_space), "space copy");
			chk(64'(mode_out), 64'(rows[r].exp_mode), "mode copy");
			chk(64'(got.valid), 64'(!rows[r].wr), "response valid");
			if (!rows[r].wr) begin
				chk(got.data, rows[r].exp_rsp, "refused read data");
			end
		end
		$display("register table test done");
		for (int i = 0; i < 64; i++) begin
			acc(tlb_fill_pkg::SEL_ENTRY, 1'b1, fill(i));
			chk(staged_out, fill(i), "staged entry");
			chk(64'(entry_ptr_out), 64'(i), "pointer held on entry write");
			acc(tlb_fill_pkg::SEL_TAG, 1'b1, 64'(i) << 13);
			chk(64'(entry_ptr_out), 64'((i + 1) % 64), "pointer after tag write");
		end
		$display("fill test done");
		for (int i = 0; i < 64; i++) begin
			acc(tlb_fill_pkg::SEL_ENTRY, 1'b0, 64'h0);
			chk(got.data, 64'h0, "entry read returns zero");
			chk(64'(got.valid), 64'h1, "entry read valid");
			chk(64'(entry_ptr_out), 64'((i + 1) % 64), "pointer after entry read");
			acc(tlb_fill_pkg::SEL_HOLD, 1'b0, 64'h0);
			chk(got.data, fill(i) & tlb_fill_pkg::PTE_KEEP_MASK, "holding data");
		end
		$display("readback walk test done");
		acc(tlb_fill_pkg::SEL_ENTRY, 1'b1, 64'h1234_5678_9abc_def1);
		acc(tlb_fill_pkg::SEL_ENTRY, 1'b0, 64'h0);
		acc(tlb_fill_pkg::SEL_HOLD, 1'b0, 64'h0);
		chk(got.data, fill(0) & tlb_fill_pkg::PTE_KEEP_MASK, "read after entry write");
		acc(tlb_fill_pkg::SEL_HOLD, 1'b1, 64'hffff_ffff_ffff_ffff);
		acc(tlb_fill_pkg::SEL_HOLD, 1'b0, 64'h0);
		chk(got.data, fill(0) & tlb_fill_pkg::PTE_KEEP_MASK, "holding write ignored");
		$display("staging and holding test done");
		@(negedge clock_in);
		timeout_reset_in = 1'b1;
		@(negedge clock_in);
		timeout_reset_in = 1'b0;
		@(negedge clock_in);
		chk(64'(entry_ptr_out), 64'h1, "pointer kept on timeout reset");
		chip_reset_in = 1'b1;
		@(negedge clock_in);
		chip_reset_in = 1'b0;
		@(negedge clock_in);
		chk(64'(entry_ptr_out), 64'h0, "pointer cleared on chip reset");
		$display("reset kinds test done");
		acc(tlb_fill_pkg::SEL_TAG, 1'b1, 64'h0);
		acc(tlb_fill_pkg::SEL_SPACE, 1'b1, 64'h550);
		chk(64'(entry_ptr_out), 64'h1, "pointer before mid reset");
		rst_b_in = 1'b0;
		repeat (2) @(negedge clock_in);
		chk(64'(entry_ptr_out), 64'h0, "pointer held in reset");
		rst_b_in = 1'b1;
		repeat (3) @(negedge clock_in);
		chk(staged_out, 64'h0, "staged after mid reset");
		chk(64'(space_number_out), 64'h0, "space after mid reset");
		chk(64'(entry_ptr_out), 64'h0, "pointer after mid reset");
		$display("mid-run reset test done");
		acc(tlb_fill_pkg::SEL_ENTRY, 1'b0, 64'h0);
		for (int i = 0; i < 62; i++) begin
			acc(tlb_fill_pkg::SEL_TAG, 1'b1, 64'h0);
		end
		chk(64'(entry_ptr_out), 64'h3f, "pointer before skip");
		acc(tlb_fill_pkg::SEL_TAG, 1'b1, 64'h0);
		chk(64'(entry_ptr_out), 64'h1, "last read slot skipped");
		$display("replacement skip test done");
		test_done();
	end
endmodule
